// ### core/tit_core.sv
/*
 Trap instruction value builder and trap return state update, with an
 AXI4-Lite register slave. Assumes the trap and retire stages present
 one-cycle requests synchronous to mclk and only issue legal returns.
*/
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tit_core (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        trapValid,
  input  wire logic        trapIsIrq,
  input  wire logic        trapToHyp,
  input  wire logic [4:0]  trapCause,
  input  wire logic        trapStd,
  input  wire logic [31:0] trapInsn,
  input  wire logic [63:0] trapFaultVa,
  input  wire logic [63:0] trapOrigVa,
  input  wire logic        trapImplicit,
  input  wire logic        trapGpaNonzero,
  input  wire logic        trapImplicitWrite,
  input  wire logic        retValid,
  input  wire logic        retMachine,
  input  wire logic [63:0] mepc,
  input  wire logic [63:0] sepc,
  input  wire logic [63:0] vsepc,
  output logic [31:0]      machineTrapInsn,
  output logic [31:0]      hypTrapInsn,
  output logic [1:0]       curPriv,
  output logic             curVirt,
  output logic [63:0]      retPc,
  output logic             retPcValid
);
  // ********************************************************
  // Transform of a trapping instruction
  // ********************************************************
  // Compressed forms assume a 64-bit hart: func_select_field 011 is a doubleword.
  function automatic logic [31:0] xform(input logic [31:0] i,
                                        input logic [4:0]  off);
    logic [2:0] f;
    logic       st;
    logic       fp;
    logic [2:0] f3;
    logic [4:0] r;
    logic [6:0] op;
    logic [31:0] y;
    f  = i[15:13];
    st = f[2];
    fp = (f[1:0] == 2'h1);
    f3 = fp ? 3'h3 : {1'b0, f[1:0]};
    r  = (i[1:0] == 2'h0) ? {2'h1, i[4:2]} : (st ? i[6:2] : i[11:7]);
    op = {1'b0, st, 2'h0, fp, 2'h3};
    y  = 32'h0000_0000;
    if (i[1:0] != 2'h3) begin
      if (i[1:0] != 2'h1 && f[1:0] != 2'h0) begin
        y = st ? {7'h0, r, off, f3, 5'h0, op}
               : {12'h0, off, f3, r, op};
        y[1] = 1'b0;
      end
    end else if (i[6:0] == tit_pkg::OP_LOAD ||
                 i[6:0] == tit_pkg::OP_FLOAD) begin
      y = {12'h0, off, i[14:0]};
    end else if (i[6:0] == tit_pkg::OP_STORE ||
                 i[6:0] == tit_pkg::OP_FSTOR) begin
      y = {7'h0, i[24:20], off, i[14:12], 5'h0, i[6:0]};
    end else if (i[6:0] == tit_pkg::OP_AMO) begin
      y = {i[31:20], off, i[14:0]};
    end else if (i[6:0] == tit_pkg::OP_SYS &&
                 i[14:12] == tit_pkg::F3_HYP &&
                 i[31:29] == 3'h3) begin
      y = {i[31:20], off, i[14:0]};
    end
    return y;
  endfunction

  logic        memCause;
  logic        gpfCause;
  logic        pseudo;
  logic [63:0] vaDiff;
  logic [31:0] psiVal;
  logic [31:0] insnVal;
  logic [31:0] next_mti;
  logic [31:0] next_hti;
  logic [7:0]  mstat;
  logic [3:0]  sstat;
  logic [3:0]  vsstat;
  logic [3:0]  ctrl;

  // Value written on a trap; zero whenever no defined value applies.
  always_comb begin
    memCause = trapCause == tit_pkg::CA_LD_MIS ||
               trapCause == tit_pkg::CA_LD_ACC ||
               trapCause == tit_pkg::CA_ST_MIS ||
               trapCause == tit_pkg::CA_ST_ACC ||
               trapCause == tit_pkg::CA_LD_PF ||
               trapCause == tit_pkg::CA_ST_PF ||
               trapCause == tit_pkg::CA_LD_GPF ||
               trapCause == tit_pkg::CA_ST_GPF;
    gpfCause = trapCause == tit_pkg::CA_IN_GPF ||
               trapCause == tit_pkg::CA_LD_GPF ||
               trapCause == tit_pkg::CA_ST_GPF;
    pseudo = !trapIsIrq && gpfCause && trapImplicit &&
             trapGpaNonzero;
    vaDiff = trapFaultVa - trapOrigVa;
    // Writes are reported only when hardware updates guest A/D bits.
    if (trapImplicitWrite && ctrl[tit_pkg::CT_ADUPD]) begin
      psiVal = ctrl[tit_pkg::CT_WIDE] ? tit_pkg::PSI_WR64
                                      : tit_pkg::PSI_WR32;
    end else begin
      psiVal = ctrl[tit_pkg::CT_WIDE] ? tit_pkg::PSI_RD64
                                      : tit_pkg::PSI_RD32;
    end
    if (trapIsIrq) begin
      insnVal = 32'h0000_0000;
    end else if (pseudo) begin
      insnVal = psiVal;
    end else if (memCause && trapStd && ctrl[tit_pkg::CT_XFORM]) begin
      insnVal = xform(trapInsn, vaDiff[4:0]);
    end else begin
      insnVal = 32'h0000_0000;
    end
    next_mti = machineTrapInsn;
    next_hti = hypTrapInsn;
    if (trapValid && trapToHyp) begin
      next_hti = insnVal;
    end else if (trapValid) begin
      next_mti = insnVal;
    end
  end

  // Trap instruction registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      machineTrapInsn <= 32'h0000_0000;
      hypTrapInsn     <= 32'h0000_0000;
    end else begin
      machineTrapInsn <= next_mti;
      hypTrapInsn     <= next_hti;
    end
  end

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  logic [7:0]  awq;
  logic [31:0] wq;
  logic [3:0]  sq;
  logic        wrFire;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [7:0]  next_awq;
  logic [31:0] next_wq;
  logic [3:0]  next_sq;
  logic [7:0]  wa;
  logic [7:0]  ra;

  // Address and data are taken in either order; the write happens once
  // both are held and no response is pending.
  always_comb begin
    wa = {awq[7:2], 2'h0};
    ra = {araddr[7:2], 2'h0};
    wrFire = !awready && !wready && !bvalid;
    next_awq = (awready && awvalid) ? awaddr : awq;
    next_wq  = (wready && wvalid) ? wdata : wq;
    next_sq  = (wready && wvalid) ? wstrb : sq;
    next_awready = awready ? !awvalid : (bvalid && bready);
    next_wready  = wready ? !wvalid : (bvalid && bready);
    next_bvalid  = bvalid ? !bready : wrFire;
    next_bresp   = bresp;
    if (wrFire) begin
      next_bresp = (wa <= tit_pkg::ADDR_HTI) ? tit_pkg::RESP_OKAY
                                             : tit_pkg::RESP_SLVERR;
    end
    next_arready = arready ? !arvalid : (rvalid && rready);
    next_rvalid  = rvalid ? !rready : (arready && arvalid);
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arready && arvalid) begin
      next_rresp = tit_pkg::RESP_OKAY;
      if (ra == tit_pkg::ADDR_MSTAT) begin
        next_rdata = {24'h0, mstat};
      end else if (ra == tit_pkg::ADDR_SSTAT) begin
        next_rdata = {28'h0, sstat};
      end else if (ra == tit_pkg::ADDR_VSSTAT) begin
        next_rdata = {28'h0, vsstat};
      end else if (ra == tit_pkg::ADDR_CTRL) begin
        next_rdata = {28'h0, ctrl};
      end else if (ra == tit_pkg::ADDR_MTI) begin
        next_rdata = machineTrapInsn;
      end else if (ra == tit_pkg::ADDR_HTI) begin
        next_rdata = hypTrapInsn;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = tit_pkg::RESP_SLVERR;
      end
    end
  end

  // Bus handshake registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= tit_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= tit_pkg::RESP_OKAY;
      awq     <= 8'h00;
      wq      <= 32'h0000_0000;
      sq      <= 4'h0;
    end else begin
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      awq     <= next_awq;
      wq      <= next_wq;
      sq      <= next_sq;
    end
  end

  // ********************************************************
  // Trap return
  // ********************************************************
  logic [7:0]  next_mstat;
  logic [3:0]  next_sstat;
  logic [3:0]  next_vsstat;
  logic [3:0]  next_ctrl;
  logic [63:0] next_retPc;
  logic        next_retPcValid;
  logic        wrLow;
  // Position of the current privilege field in the machine status.
  localparam int MP = tit_pkg::MS_PRIV;

  // A return in the same cycle as a software status write wins, since
  // the retiring instruction already committed on the old state.
  always_comb begin
    next_mstat  = mstat;
    next_sstat  = sstat;
    next_vsstat = vsstat;
    next_ctrl   = ctrl;
    next_retPc  = retPc;
    next_retPcValid = 1'b0;
    wrLow = wrFire && sq[0];
    if (wrLow && wa == tit_pkg::ADDR_MSTAT) begin
      next_mstat = wq[7:0];
    end else if (wrLow && wa == tit_pkg::ADDR_SSTAT) begin
      next_sstat = wq[3:0];
    end else if (wrLow && wa == tit_pkg::ADDR_VSSTAT) begin
      next_vsstat = wq[3:0];
    end else if (wrLow && wa == tit_pkg::ADDR_CTRL) begin
      next_ctrl = wq[3:0];
    end
    if (retValid && retMachine) begin
      next_mstat = mstat;
      next_mstat[MP+1:MP] = mstat[tit_pkg::MS_MPP+:2];
      next_mstat[tit_pkg::MS_VIRT] = (mstat[tit_pkg::MS_MPP+:2] !=
        tit_pkg::PRIV_M) && mstat[tit_pkg::MS_MPV];
      next_mstat[tit_pkg::MS_MPP+:2] = tit_pkg::PRIV_U;
      next_mstat[tit_pkg::MS_MPV]  = 1'b0;
      next_mstat[tit_pkg::MS_MIE]  = mstat[tit_pkg::MS_MACHINE_PREV_IRQ_ENABLE];
      next_mstat[tit_pkg::MS_MACHINE_PREV_IRQ_ENABLE] = 1'b1;
      next_retPc = mepc;
      next_retPcValid = 1'b1;
    end else if (retValid && !mstat[tit_pkg::MS_VIRT]) begin
      next_mstat = mstat;
      next_sstat = sstat;
      next_mstat[MP+1:MP] = {1'b0, sstat[tit_pkg::SS_PP]};
      next_mstat[tit_pkg::MS_VIRT] = sstat[tit_pkg::SS_XTRA];
      next_sstat[tit_pkg::SS_XTRA] = 1'b0;
      next_sstat[tit_pkg::SS_PP]   = 1'b0;
      next_sstat[tit_pkg::SS_IE]   = sstat[tit_pkg::SS_PIE];
      next_sstat[tit_pkg::SS_PIE]  = 1'b1;
      if (ctrl[tit_pkg::CT_DBLT] && mstat[MP+1:MP] == tit_pkg::PRIV_S &&
          sstat[tit_pkg::SS_XTRA] && !sstat[tit_pkg::SS_PP]) begin
        next_vsstat[tit_pkg::SS_XTRA] = 1'b0;
      end
      next_retPc = sepc;
      next_retPcValid = 1'b1;
    end else if (retValid) begin
      next_mstat = mstat;
      next_vsstat = vsstat;
      next_mstat[MP+1:MP] = {1'b0, vsstat[tit_pkg::SS_PP]};
      next_vsstat[tit_pkg::SS_PP]  = 1'b0;
      next_vsstat[tit_pkg::SS_IE]  = vsstat[tit_pkg::SS_PIE];
      next_vsstat[tit_pkg::SS_PIE] = 1'b1;
      if (ctrl[tit_pkg::CT_DBLT]) begin
        next_vsstat[tit_pkg::SS_XTRA] = 1'b0;
      end
      next_retPc = vsepc;
      next_retPcValid = 1'b1;
    end
  end

  // Status, control and return target registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mstat      <= tit_pkg::MSTAT_RST;
      sstat      <= tit_pkg::SSTAT_RST;
      vsstat     <= tit_pkg::SSTAT_RST;
      ctrl       <= tit_pkg::CTRL_RST;
      curPriv    <= tit_pkg::PRIV_M;
      curVirt    <= 1'b0;
      retPc      <= 64'h0000_0000_0000_0000;
      retPcValid <= 1'b0;
    end else begin
      mstat      <= next_mstat;
      sstat      <= next_sstat;
      vsstat     <= next_vsstat;
      ctrl       <= next_ctrl;
      curPriv    <= next_mstat[MP+1:MP];
      curVirt    <= next_mstat[tit_pkg::MS_VIRT];
      retPc      <= next_retPc;
      retPcValid <= next_retPcValid;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  logic mTrap;
  assign mTrap = trapValid && !trapToHyp;
  sequence s_machine_trap_return;
    retValid && retMachine;
  endsequence
  sequence s_sret0;
    retValid && !retMachine && !mstat[tit_pkg::MS_VIRT];
  endsequence

  property p_irq_zero;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && trapIsIrq |=> machineTrapInsn == 32'h0000_0000;
  endproperty
  a_irq_zero: assert property (p_irq_zero)
    else $error("interrupt trap left nonzero value");

  property p_target;
    @(posedge mclk) disable iff (!arst_n)
    trapValid && trapToHyp |=> $stable(machineTrapInsn);
  endproperty
  a_target: assert property (p_target)
    else $error("hypervisor trap wrote machine register");

  property p_pseudo_rd;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && pseudo && !trapImplicitWrite |=> machineTrapInsn ==
      ($past(ctrl[1]) ? 32'h0000_3000 : 32'h0000_2000);
  endproperty
  a_pseudo_rd: assert property (p_pseudo_rd)
    else $error("wrong read pseudo value");

  property p_pseudo_wr;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && pseudo && !ctrl[tit_pkg::CT_ADUPD] |=>
      machineTrapInsn != 32'h0000_0000 && !machineTrapInsn[5];
  endproperty
  a_pseudo_wr: assert property (p_pseudo_wr)
    else $error("write pseudo without hardware update");

  property p_nomem;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && !memCause && !pseudo |=> machineTrapInsn == 32'h0000_0000;
  endproperty
  a_nomem: assert property (p_nomem)
    else $error("transform outside memory exceptions");

  property p_lowbits;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && !pseudo |=> machineTrapInsn == 32'h0000_0000 ||
      machineTrapInsn[1:0] ==
      ($past(trapInsn[1:0]) == 2'h3 ? 2'h3 : 2'h1);
  endproperty
  a_lowbits: assert property (p_lowbits)
    else $error("transformed low bits wrong");

  property p_amo;
    @(posedge mclk) disable iff (!arst_n)
    mTrap && !trapIsIrq && !pseudo && memCause && trapStd && ctrl[0] &&
      trapInsn[6:0] == tit_pkg::OP_AMO |=>
      machineTrapInsn[31:20] == $past(trapInsn[31:20]) &&
      machineTrapInsn[14:0] == $past(trapInsn[14:0]) &&
      machineTrapInsn[19:15] == $past(vaDiff[4:0]);
  endproperty
  a_amo: assert property (p_amo)
    else $error("atomic transform fields wrong");

  property p_machine_trap_return;
    @(posedge mclk) disable iff (!arst_n)
    s_machine_trap_return |=> curPriv == $past(mstat[6:5]) && mstat[6:5] == 2'h0 &&
      mstat[tit_pkg::MS_MACHINE_PREV_IRQ_ENABLE] && retPcValid && retPc == $past(mepc);
  endproperty
  a_machine_trap_return: assert property (p_machine_trap_return)
    else $error("machine return state wrong");

  property p_machine_trap_return_virt;
    @(posedge mclk) disable iff (!arst_n)
    s_machine_trap_return ##0 mstat[6:5] == tit_pkg::PRIV_M |=> !curVirt;
  endproperty
  a_machine_trap_return_virt: assert property (p_machine_trap_return_virt)
    else $error("virtualization on after return to machine");

  property p_sret0;
    @(posedge mclk) disable iff (!arst_n)
    s_sret0 |=> curVirt == $past(sstat[3]) && sstat[3:2] == 2'h0 &&
      sstat[0] == $past(sstat[1]) && retPc == $past(sepc);
  endproperty
  a_sret0: assert property (p_sret0)
    else $error("supervisor return state wrong");
endmodule
`default_nettype wire

// ### core/tit_pkg.sv
/*
 Constants for the trap instruction transform and trap return block.
 Assumes a 64-bit hart with the hypervisor extension and 32-bit data
 on the register bus; each register takes one aligned word.
*/
package tit_pkg;
  // ********************************************************
  // Register map and field positions
  // ********************************************************
  localparam logic [7:0] ADDR_MSTAT  = 8'h00;
  localparam logic [7:0] ADDR_SSTAT  = 8'h04;
  localparam logic [7:0] ADDR_VSSTAT = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_MTI    = 8'h10;
  localparam logic [7:0] ADDR_HTI    = 8'h14;
  // Machine status: privilege, virtualization and machine stack.
  localparam int MS_PRIV = 0;
  localparam int MS_VIRT = 2;
  localparam int MS_MIE  = 3;
  localparam int MS_MACHINE_PREV_IRQ_ENABLE = 4;
  localparam int MS_MPP  = 5;
  localparam int MS_MPV  = 7;
  // Supervisor status and guest status share one layout.
  localparam int SS_IE   = 0;
  localparam int SS_PIE  = 1;
  localparam int SS_PP   = 2;
  localparam int SS_XTRA = 3;
  // Control bits.
  localparam int CT_XFORM = 0;
  localparam int CT_WIDE  = 1;
  localparam int CT_ADUPD = 2;
  localparam int CT_DBLT  = 3;
  localparam logic [7:0] MSTAT_RST = 8'h03;
  localparam logic [3:0] SSTAT_RST = 4'h0;
  localparam logic [3:0] CTRL_RST  = 4'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************************************
  // Privilege levels and exception causes
  // ********************************************************
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam logic [4:0] CA_LD_MIS = 5'h04;
  localparam logic [4:0] CA_LD_ACC = 5'h05;
  localparam logic [4:0] CA_ST_MIS = 5'h06;
  localparam logic [4:0] CA_ST_ACC = 5'h07;
  localparam logic [4:0] CA_LD_PF  = 5'h0d;
  localparam logic [4:0] CA_ST_PF  = 5'h0f;
  localparam logic [4:0] CA_IN_GPF = 5'h14;
  localparam logic [4:0] CA_LD_GPF = 5'h15;
  localparam logic [4:0] CA_ST_GPF = 5'h17;
  // ********************************************************
  // Opcodes and pseudoinstruction values
  // ********************************************************
  localparam logic [6:0] OP_LOAD  = 7'h03;
  localparam logic [6:0] OP_FLOAD = 7'h07;
  localparam logic [6:0] OP_STORE = 7'h23;
  localparam logic [6:0] OP_FSTOR = 7'h27;
  localparam logic [6:0] OP_AMO   = 7'h2f;
  localparam logic [6:0] OP_SYS   = 7'h73;
  localparam logic [2:0] F3_HYP   = 3'h4;
  localparam logic [31:0] PSI_RD32 = 32'h0000_2000;
  localparam logic [31:0] PSI_WR32 = 32'h0000_2020;
  localparam logic [31:0] PSI_RD64 = 32'h0000_3000;
  localparam logic [31:0] PSI_WR64 = 32'h0000_3020;
endpackage

// ### core/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### test/test_trap_insn_transform_and_return.sv
/*
 Self-checking bench for the trap instruction transform and trap return
 block. Assumes tit_core with its AXI4-Lite slave; the bench is the master
 and drives the trap and retire requests itself.
*/
`timescale 1ns/1ps
`default_nettype none
module test_trap_insn_transform_and_return;
  logic        mclk = 1'b0, arst_n = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, trapInsn = '0;
  logic        trapValid = 1'b0, trapIsIrq = 1'b0, trapToHyp = 1'b0;
  logic        trapStd = 1'b0, trapImplicit = 1'b0, trapGpaNonzero = 1'b0;
  logic        trapImplicitWrite = 1'b0, retValid = 1'b0, retMachine = 1'b0;
  logic [4:0]  trapCause = '0;
  logic [63:0] trapFaultVa = '0, trapOrigVa = '0;
  logic [63:0] mepc = '0, sepc = '0, vsepc = '0;
  logic [63:0] retPc;
  logic        awready, wready, bvalid, arready, rvalid, curVirt, retPcValid;
  logic [1:0]  bresp, rresp, curPriv, rsp;
  logic [31:0] rdata, machineTrapInsn, hypTrapInsn, rdv;
  int          fail_count = 0, comparisons = 0, cycles = 0;

  tit_core dut (.mclk, .arst_n, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .trapValid, .trapIsIrq, .trapToHyp, .trapCause, .trapStd,
    .trapInsn, .trapFaultVa, .trapOrigVa, .trapImplicit, .trapGpaNonzero,
    .trapImplicitWrite, .retValid, .retMachine, .mepc, .sepc, .vsepc,
    .machineTrapInsn, .hypTrapInsn, .curPriv, .curVirt, .retPc,
    .retPcValid);

  // ********************************************************
  // Clock, timeout and reporting
  // ********************************************************
  always #12.5 mclk = ~mclk;

  // A hung handshake would stall the run forever, so cap it here.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ********************************************************
  // Bus and request tasks
  // ********************************************************
  // Each channel is released only at the edge where its ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rdv = rdata;
    rsp = rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    check(n, rdv, e);
  endtask

  // Flags f are hyp, irq, std, implicit, gpa nonzero, implicit write.
  task automatic tx(input logic [5:0] f, input logic [4:0] c,
                    input logic [31:0] i, input logic [4:0] off,
                    input logic [31:0] e);
    @(posedge mclk);
    {trapToHyp, trapIsIrq, trapStd, trapImplicit, trapGpaNonzero,
     trapImplicitWrite} <= f;
    trapCause   <= c;
    trapInsn    <= i;
    trapOrigVa  <= 64'h0000_0000_8000_1ffe;
    trapFaultVa <= 64'h0000_0000_8000_1ffe + {59'h0, off};
    trapValid   <= 1'b1;
    @(posedge mclk);
    trapValid <= 1'b0;
    rc(f[5] ? tit_pkg::ADDR_HTI : tit_pkg::ADDR_MTI, e, "trap insn");
  endtask

  // Return targets differ by shift s, so a wrong source pc shows up.
  task automatic ret(input logic m, input int s, input logic [2:0] pv);
    logic [63:0] e;
    @(posedge mclk);
    e = 64'(cycles) << s;
    retValid   <= 1'b1;
    retMachine <= m;
    mepc       <= 64'(cycles);
    sepc       <= 64'(cycles) << 4;
    vsepc      <= 64'(cycles) << 8;
    @(posedge mclk);
    retValid <= 1'b0;
    #1;
    check("ret pulse", retPcValid, 1'b1);
    check("virt and priv", {curVirt, curPriv}, pv);
    check("ret pc", retPc, e);
    @(posedge mclk);
    #1;
    check("ret pulse end", retPcValid, 1'b0);
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rc(tit_pkg::ADDR_MSTAT, 32'h0000_0003, "mstat reset");
    rc(tit_pkg::ADDR_CTRL, 32'h0000_0001, "ctrl reset");
    rd(8'h20);
    check("rd resp", rsp, tit_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0000_00ff);
    check("wr resp", rsp, tit_pkg::RESP_SLVERR);
    wr(tit_pkg::ADDR_MTI, 32'h0000_00ff);
    rc(tit_pkg::ADDR_MTI, 32'h0000_0000, "mti read only");
    // Transforms, zero cases and target selection.
    tx(6'h08, tit_pkg::CA_LD_MIS, 32'h00c3_2283, 5'd3, 32'h0001_a283);
    tx(6'h08, 5'h02, 32'h00c3_2283, 5'd0, 32'h0000_0000);
    tx(6'h28, tit_pkg::CA_ST_PF, 32'h0075_3423, 5'd0, 32'h0070_3023);
    tx(6'h08, tit_pkg::CA_ST_ACC, 32'h0021_a0af, 5'd2, 32'h0021_20af);
    tx(6'h28, tit_pkg::CA_LD_GPF, 32'h6804_c273, 5'd1, 32'h6800_c273);
    tx(6'h08, tit_pkg::CA_LD_PF, 32'h0000_4044, 5'd0, 32'h0000_2481);
    rc(tit_pkg::ADDR_HTI, 32'h6800_c273, "hti kept");
    tx(6'h18, 5'h07, 32'h00c3_2283, 5'd0, 32'h0000_0000);
    // Pseudo values over width, hardware update and access kind.
    for (int k = 0; k < 8; k++) begin
      wr(tit_pkg::ADDR_CTRL, {29'h0, k[1:0], 1'b1});
      tx({k[0] ^ k[1], 4'b0111, k[2]}, tit_pkg::CA_LD_GPF, 32'h00c3_2283,
         5'd0, {18'h0, 1'b1, k[0], 6'h0, k[1] & k[2], 5'h0});
    end
    // Trap returns, double-trap option on.
    wr(tit_pkg::ADDR_CTRL, 32'h0000_0009);
    wr(tit_pkg::ADDR_MSTAT, 32'h0000_00b3);
    ret(1'b1, 0, 3'b101);
    rc(tit_pkg::ADDR_MSTAT, 32'h0000_001d, "mstat machine_trap_return");
    wr(tit_pkg::ADDR_MSTAT, 32'h0000_00eb);
    ret(1'b1, 0, 3'b011);
    rc(tit_pkg::ADDR_MSTAT, 32'h0000_0013, "mstat to m");
    wr(tit_pkg::ADDR_MSTAT, 32'h0000_0001);
    wr(tit_pkg::ADDR_SSTAT, 32'h0000_0006);
    ret(1'b0, 4, 3'b001);
    rc(tit_pkg::ADDR_SSTAT, 32'h0000_0003, "sstat super_trap_return");
    wr(tit_pkg::ADDR_SSTAT, 32'h0000_0008);
    wr(tit_pkg::ADDR_VSSTAT, 32'h0000_0008);
    ret(1'b0, 4, 3'b100);
    rc(tit_pkg::ADDR_SSTAT, 32'h0000_0002, "sstat to vu");
    rc(tit_pkg::ADDR_VSSTAT, 32'h0000_0000, "guest flag vu");
    wr(tit_pkg::ADDR_MSTAT, 32'h0000_0005);
    wr(tit_pkg::ADDR_VSSTAT, 32'h0000_000e);
    ret(1'b0, 8, 3'b101);
    rc(tit_pkg::ADDR_VSSTAT, 32'h0000_0003, "vsstat super_trap_return");
    tally_and_finish();
  end
endmodule
`default_nettype wire
